// file: dv/osdcp_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "osdcp_defs.svh"

module testbench
  import osdcp_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, vsync, pready, pslverr, err, vs_next;
  logic [7:0] paddr, a;
  logic [31:0] pwdata, prdata, rdata, exp_w;
  logic [10:0] cur_w, cur_h;
  osdcp_pix_type pix;
  osdcp_pal_type pal;
  int n_mismatch = 0;
  int n_checks = 0;

  osdcp_top #(.ADDR_W(8)) dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .VSYNC_EVENT(vsync), .PIX_REQ(pix), .PAL_OUT(pal),
    .CUR_WIDTH(cur_w), .CUR_HEIGHT(cur_h));

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a hang anywhere counts as a mismatch, so the run ends in a failed verdict
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_pix(input string name, input osdcp_pal_type exp, input osdcp_pal_type got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic we, input logic [7:0] addr, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= we;
    paddr <= addr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    i = 0;
    while (pready !== 1'b1 && i < 50) begin
      @(posedge clk);
      i++;
    end
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_of_test;
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a pending sync pulse goes out in the cycle right after the write lands
    vsync <= vs_next;
    // idle edge so that psel is never assigned twice in one time step
    @(posedge clk);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    chk_word(name, exp, rdata);
    chk_word("error flag", 32'h0000_0000, {31'h0000_0000, err});
  endtask

  task automatic cur_chk(input logic [10:0] w, input logic [10:0] h);
    #1;
    chk_word("cursor width", {21'h00_0000, w}, {21'h00_0000, cur_w});
    chk_word("cursor height", {21'h00_0000, h}, {21'h00_0000, cur_h});
    @(posedge clk);
  endtask

  task automatic vsync_chk(input logic [10:0] w, input logic [10:0] h);
    vsync <= 1'b1;
    @(posedge clk);
    vsync <= 1'b0;
    cur_chk(w, h);
  endtask

  // distinct entry value per window and index
  function automatic logic [7:0] pal_val(input logic w, input logic [3:0] k);
    return w ? {4'hA, ~k} : {4'h3, k};
  endfunction

  task automatic pix_chk(input logic w, input osdcp_bpp_type m, input logic [3:0] v,
                         input logic [3:0] k);
    osdcp_pal_type e;
    e.valid = 1'b1;
    e.addr = pal_val(w, k);
    pix <= '{valid: 1'b1, win: w, mode: m, value: v};
    @(posedge clk);
    pix <= '0;
    #1;
    chk_pix("palette out", e, pal);
    @(posedge clk);
    #1;
    chk_pix("palette idle", '0, pal);
    @(posedge clk);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    vsync = 1'b0;
    vs_next = 1'b0;
    pix = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cur_chk(11'h001, 11'h001);
    rd_chk("reserved a", `OSDCP_OFF_RSV_A, 32'h0000_0000);
    apb(1'b1, `OSDCP_OFF_RSV_B, 32'hFFFF_FFFF);
    rd_chk("reserved b", `OSDCP_OFF_RSV_B, 32'h0000_0000);
    $display("test reset and reserved done");
    // size written now must not show before the sync event
    apb(1'b1, `OSDCP_OFF_CUR_WIDTH, 32'h0000_07FF);
    apb(1'b1, `OSDCP_OFF_CUR_HEIGHT, 32'h0000_0123);
    cur_chk(11'h001, 11'h001);
    rd_chk("width reg", `OSDCP_OFF_CUR_WIDTH, 32'h0000_07FF);
    rd_chk("height reg", `OSDCP_OFF_CUR_HEIGHT, 32'h0000_0123);
    vsync_chk(11'h7FF, 11'h123);
    rd_chk("cursor status", `OSDCP_OFF_CUR_STATUS, 32'h0123_07FF);
    apb(1'b1, `OSDCP_OFF_CUR_WIDTH, 32'h0000_0000);
    apb(1'b1, `OSDCP_OFF_CUR_HEIGHT, 32'h0000_0000);
    vsync_chk(11'h001, 11'h001);
    apb(1'b1, `OSDCP_OFF_CUR_HEIGHT, 32'h0000_0005);
    vsync_chk(11'h000, 11'h005);
    // a height write answered by the very next sync event
    vs_next = 1'b1;
    apb(1'b1, `OSDCP_OFF_CUR_HEIGHT, 32'h0000_0042);
    vs_next = 1'b0;
    vsync <= 1'b0;
    cur_chk(11'h000, 11'h042);
    $display("test cursor size done");
    // both tables filled before any readback, so crosstalk shows
    for (int w = 0; w < 2; w++) begin
      for (int p = 0; p < 8; p++) begin
        a = (w == 1 ? `OSDCP_OFF_WIN1_BASE : `OSDCP_OFF_WIN0_BASE) + 8'(4 * p);
        exp_w = {16'h0000, pal_val(w[0], 4'(2*p+1)), pal_val(w[0], 4'(2*p))};
        apb(1'b1, a, exp_w);
      end
    end
    for (int w = 0; w < 2; w++) begin
      for (int p = 0; p < 8; p++) begin
        a = (w == 1 ? `OSDCP_OFF_WIN1_BASE : `OSDCP_OFF_WIN0_BASE) + 8'(4 * p);
        exp_w = {16'h0000, pal_val(w[0], 4'(2*p+1)), pal_val(w[0], 4'(2*p))};
        rd_chk("palette map", a, exp_w);
      end
    end
    $display("test palette map registers done");
    for (int w = 0; w < 2; w++) begin
      for (int v = 0; v < 16; v++) begin
        pix_chk(w[0], OSDCP_BPP4, v[3:0], v[3:0]);
        if (v < 4) pix_chk(w[0], OSDCP_BPP2, v[3:0], 4'(v * 5));
        if (v < 2) pix_chk(w[0], OSDCP_BPP1, v[3:0], 4'(v * 15));
      end
    end
    // a depth code outside the three defined ones falls back to entry 0
    pix_chk(1'b1, osdcp_bpp_type'(3'b011), 4'h9, 4'h0);
    $display("test pixel translation done");
    apb(1'b0, 8'h54, 32'h0000_0000);
    chk_word("unmapped data", 32'h0000_0000, rdata);
    chk_word("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    $display("test unmapped address done");
    // a second reset in mid-run brings back the 1x1 cursor and empty tables
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cur_chk(11'h001, 11'h001);
    rd_chk("width after reset", `OSDCP_OFF_CUR_WIDTH, 32'h0000_0000);
    rd_chk("map after reset", `OSDCP_OFF_WIN1_BASE + 8'h1C, 32'h0000_0000);
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule

`default_nettype wire

// file: inc/osdcp_defs.svh
`ifndef OSDCP_DEFS_SVH
`define OSDCP_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OSDCP_OFF_CUR_WIDTH 8'h00
`define OSDCP_OFF_CUR_HEIGHT 8'h04
`define OSDCP_OFF_RSV_A 8'h08
`define OSDCP_OFF_RSV_B 8'h0C
`define OSDCP_OFF_WIN0_BASE 8'h10
`define OSDCP_OFF_WIN1_BASE 8'h30
`define OSDCP_OFF_CUR_STATUS 8'h50
`define OSDCP_WIN_SPAN 8'h20

// ****************************************
// field positions
// ****************************************
`define OSDCP_CUR_MSB 10
`define OSDCP_EVEN_MSB 7
`define OSDCP_EVEN_LSB 0
`define OSDCP_ODD_MSB 15
`define OSDCP_ODD_LSB 8
`define OSDCP_STAT_H_LSB 16

// ****************************************
// reset values
// ****************************************
`define OSDCP_RST_WORD 32'h0000_0000
`define OSDCP_RST_CUR 11'h000
`define OSDCP_RST_PAL 8'h00
`define OSDCP_CUR_MIN 11'h001

`endif

// file: inc/osdcp_pkg.sv
package osdcp_pkg;

  // bits per pixel of a bitmap window, one-hot
  typedef enum logic [2:0] {
    OSDCP_BPP1 = 3'b001,
    OSDCP_BPP2 = 3'b010,
    OSDCP_BPP4 = 3'b100
  } osdcp_bpp_type;

  // one bitmap pixel to translate
  typedef struct packed {
    logic valid;
    logic win;
    osdcp_bpp_type mode;
    logic [3:0] value;
  } osdcp_pix_type;

  // translated palette address
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } osdcp_pal_type;

endpackage

// file: rtl/osdcp_top.sv
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "osdcp_defs.svh"

module osdcp_top
  import osdcp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // display timing
  input wire logic VSYNC_EVENT,
  // pixel translation
  input wire osdcp_pix_type PIX_REQ,
  output osdcp_pal_type PAL_OUT,
  // latched cursor size
  output logic [10:0] CUR_WIDTH,
  output logic [10:0] CUR_HEIGHT
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the decode reads the whole low address byte, so narrower buses cannot reach it
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 8 and 32");
  end

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] off;
  logic setup;
  logic wr_en;
  logic sel_cw, sel_ch, sel_rsv, sel_w0, sel_w1, sel_st, hit;
  logic [2:0] pair;
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;
  logic slverr_ff;
  logic [10:0] cur_w_shd_ff;
  logic [10:0] cur_h_shd_ff;
  logic [10:0] cur_w_act_ff;
  logic [10:0] cur_h_act_ff;
  logic [1:0][15:0][7:0] pal_ff;
  logic [3:0] nxt_idx;
  osdcp_pal_type pal_out_ff;
  logic [7:0] w0_rel, w1_rel;

  // ****************************************
  // apb decode
  // ****************************************
  // only the low byte of the address selects; upper bits alias
  assign off = PADDR[7:0];
  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE && hit;
  assign w0_rel = off - `OSDCP_OFF_WIN0_BASE;
  assign w1_rel = off - `OSDCP_OFF_WIN1_BASE;

  // address decode, one word per register
  always_comb begin
    sel_cw = 1'b0;
    sel_ch = 1'b0;
    sel_rsv = 1'b0;
    sel_w0 = 1'b0;
    sel_w1 = 1'b0;
    sel_st = 1'b0;
    pair = 3'd0;
    if (off[1:0] != 2'b00) begin
      sel_cw = 1'b0;
    end else if (off == `OSDCP_OFF_CUR_WIDTH) begin
      sel_cw = 1'b1;
    end else if (off == `OSDCP_OFF_CUR_HEIGHT) begin
      sel_ch = 1'b1;
    end else if (off == `OSDCP_OFF_RSV_A || off == `OSDCP_OFF_RSV_B) begin
      sel_rsv = 1'b1;
    end else if (off >= `OSDCP_OFF_WIN0_BASE && off < `OSDCP_OFF_WIN1_BASE) begin
      sel_w0 = 1'b1;
      pair = w0_rel[4:2];
    end else if (off >= `OSDCP_OFF_WIN1_BASE && off < `OSDCP_OFF_CUR_STATUS) begin
      sel_w1 = 1'b1;
      pair = w1_rel[4:2];
    end else if (off == `OSDCP_OFF_CUR_STATUS) begin
      sel_st = 1'b1;
    end
  end

  assign hit = sel_cw || sel_ch || sel_rsv || sel_w0 || sel_w1 || sel_st;

  // read mux; reserved words and upper bits read as zero
  always_comb begin
    nxt_rdata = `OSDCP_RST_WORD;
    if (sel_cw) begin
      nxt_rdata[`OSDCP_CUR_MSB:0] = cur_w_shd_ff;
    end else if (sel_ch) begin
      nxt_rdata[`OSDCP_CUR_MSB:0] = cur_h_shd_ff;
    end else if (sel_w0 || sel_w1) begin
      nxt_rdata[`OSDCP_EVEN_MSB:`OSDCP_EVEN_LSB] = pal_ff[sel_w1][{pair, 1'b0}];
      nxt_rdata[`OSDCP_ODD_MSB:`OSDCP_ODD_LSB] = pal_ff[sel_w1][{pair, 1'b1}];
    end else if (sel_st) begin
      nxt_rdata[`OSDCP_CUR_MSB:0] = cur_w_act_ff;
      nxt_rdata[`OSDCP_STAT_H_LSB+10:`OSDCP_STAT_H_LSB] = cur_h_act_ff;
    end
  end

  // read data and error are captured in setup so the access phase needs no wait
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_ff <= `OSDCP_RST_WORD;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      rdata_ff <= PWRITE ? `OSDCP_RST_WORD : nxt_rdata;
      slverr_ff <= !hit;
    end
  end

  assign PREADY = 1'b1;
  assign PRDATA = rdata_ff;
  assign PSLVERR = slverr_ff;

  // ****************************************
  // cursor size
  // ****************************************
  // shadow copies take software writes; upper bits are dropped
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cur_w_shd_ff <= `OSDCP_RST_CUR;
      cur_h_shd_ff <= `OSDCP_RST_CUR;
    end else if (wr_en && sel_cw) begin
      cur_w_shd_ff <= PWDATA[`OSDCP_CUR_MSB:0];
    end else if (wr_en && sel_ch) begin
      cur_h_shd_ff <= PWDATA[`OSDCP_CUR_MSB:0];
    end
  end

  // active copies move only at vertical sync, so a frame never sees a torn size
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cur_w_act_ff <= `OSDCP_CUR_MIN;
      cur_h_act_ff <= `OSDCP_CUR_MIN;
    end else if (VSYNC_EVENT) begin
      if (cur_w_shd_ff == `OSDCP_RST_CUR && cur_h_shd_ff == `OSDCP_RST_CUR) begin
        cur_w_act_ff <= `OSDCP_CUR_MIN;
        cur_h_act_ff <= `OSDCP_CUR_MIN;
      end else begin
        cur_w_act_ff <= cur_w_shd_ff;
        cur_h_act_ff <= cur_h_shd_ff; // no line is subtracted
      end
    end
  end

  assign CUR_WIDTH = cur_w_act_ff;
  assign CUR_HEIGHT = cur_h_act_ff;

  // ****************************************
  // palette maps
  // ****************************************
  // two independent tables; each word holds an even and an odd entry
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pal_ff <= '0;
    end else if (wr_en && (sel_w0 || sel_w1)) begin
      pal_ff[sel_w1][{pair, 1'b0}] <= PWDATA[`OSDCP_EVEN_MSB:`OSDCP_EVEN_LSB];
      pal_ff[sel_w1][{pair, 1'b1}] <= PWDATA[`OSDCP_ODD_MSB:`OSDCP_ODD_LSB];
    end
  end

  // ****************************************
  // pixel translation
  // ****************************************
  // reduced depths replicate the value: 2-bit gives 0/5/A/F, 1-bit gives 0/F
  always_comb begin
    case (PIX_REQ.mode)
      OSDCP_BPP4: nxt_idx = PIX_REQ.value;
      OSDCP_BPP2: nxt_idx = {PIX_REQ.value[1:0], PIX_REQ.value[1:0]};
      OSDCP_BPP1: nxt_idx = {4{PIX_REQ.value[0]}};
      default: nxt_idx = 4'h0;
    endcase
  end

  // one registered lookup per pixel cycle toward the colour table
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pal_out_ff <= '0;
    end else begin
      pal_out_ff.valid <= PIX_REQ.valid;
      pal_out_ff.addr <= PIX_REQ.valid ? pal_ff[PIX_REQ.win][nxt_idx] : `OSDCP_RST_PAL;
    end
  end

  assign PAL_OUT = pal_out_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  logic both_zero;
  assign both_zero = cur_w_shd_ff == `OSDCP_RST_CUR && cur_h_shd_ff == `OSDCP_RST_CUR;

  property p_width_latch;
    VSYNC_EVENT && !both_zero |=> CUR_WIDTH == $past(cur_w_shd_ff);
  endproperty
  a_width_latch: assert property (p_width_latch) else $error("width not latched");

  property p_height_exact;
    VSYNC_EVENT && !both_zero |=> CUR_HEIGHT == $past(cur_h_shd_ff);
  endproperty
  a_height_exact: assert property (p_height_exact) else $error("height altered");

  property p_height_field;
    wr_en && sel_ch ##1 VSYNC_EVENT && !both_zero |=> CUR_HEIGHT == $past(PWDATA[10:0], 2);
  endproperty
  a_height_field: assert property (p_height_field) else $error("height field lost");

  property p_one_pixel;
    VSYNC_EVENT && both_zero |=> CUR_WIDTH == 11'h001 && CUR_HEIGHT == 11'h001;
  endproperty
  a_one_pixel: assert property (p_one_pixel) else $error("zero size not one pixel");

  property p_hold;
    !VSYNC_EVENT |=> $stable(CUR_WIDTH) && $stable(CUR_HEIGHT);
  endproperty
  a_hold: assert property (p_hold) else $error("cursor size moved off vsync");

  property p_rsv_zero;
    setup && !PWRITE && sel_rsv ##1 PSEL && PENABLE |-> PRDATA == 32'h0000_0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved word not zero");

  property p_pal_write;
    wr_en && sel_w0 |=> pal_ff[0][{$past(pair), 1'b1}] == $past(PWDATA[15:8]);
  endproperty
  a_pal_write: assert property (p_pal_write) else $error("odd entry misplaced");

  property p_win_indep;
    wr_en && sel_w1 |=> $stable(pal_ff[0]);
  endproperty
  a_win_indep: assert property (p_win_indep) else $error("window 1 write hit window 0");

  property p_bpp4;
    PIX_REQ.valid && PIX_REQ.mode == OSDCP_BPP4
      |=> PAL_OUT.addr == $past(pal_ff[PIX_REQ.win][PIX_REQ.value]);
  endproperty
  a_bpp4: assert property (p_bpp4) else $error("4-bit lookup wrong");

  property p_bpp2;
    PIX_REQ.valid && PIX_REQ.mode == OSDCP_BPP2 && PIX_REQ.value[1:0] == 2'd1 && PIX_REQ.win
      |=> PAL_OUT.addr == $past(pal_ff[1][5]);
  endproperty
  a_bpp2: assert property (p_bpp2) else $error("2-bit lookup not entry 5");

  property p_bpp1;
    PIX_REQ.valid && PIX_REQ.mode == OSDCP_BPP1 && PIX_REQ.value[0]
      |=> PAL_OUT.addr == $past(pal_ff[PIX_REQ.win][15]);
  endproperty
  a_bpp1: assert property (p_bpp1) else $error("1-bit lookup not entry F");

  property p_pix_valid;
    PIX_REQ.valid |=> PAL_OUT.valid;
  endproperty
  a_pix_valid: assert property (p_pix_valid) else $error("pixel lookup dropped");

  // a cycle with no request leaves the colour table address at zero
  property p_pix_idle;
    !PIX_REQ.valid |=> !PAL_OUT.valid && PAL_OUT.addr == 8'h00;
  endproperty
  a_pix_idle: assert property (p_pix_idle) else $error("idle lookup not zero");

  // pixel lookup by depth: 2-bit values 0..3 land on entries 0, 5, A and F
  property p_bpp2_any;
    PIX_REQ.valid && PIX_REQ.mode == OSDCP_BPP2
      |=> PAL_OUT.addr == $past(pal_ff[PIX_REQ.win][4'(PIX_REQ.value[1:0] * 5)]);
  endproperty
  a_bpp2_any: assert property (p_bpp2_any) else $error("2-bit lookup off subset");

  property p_bpp1_lo;
    PIX_REQ.valid && PIX_REQ.mode == OSDCP_BPP1 && !PIX_REQ.value[0]
      |=> PAL_OUT.addr == $past(pal_ff[PIX_REQ.win][0]);
  endproperty
  a_bpp1_lo: assert property (p_bpp1_lo) else $error("1-bit lookup not entry 0");

  property p_bpp1_w1;
    PIX_REQ.valid && PIX_REQ.mode == OSDCP_BPP1 && PIX_REQ.value[0] && PIX_REQ.win
      |=> PAL_OUT.addr == $past(pal_ff[1][15]);
  endproperty
  a_bpp1_w1: assert property (p_bpp1_w1) else $error("window 1 1-bit not entry F");

  // bus side: shadow read-back shows the field with the upper bits clear
  property p_cw_rd;
    setup && !PWRITE && sel_cw ##1 PSEL && PENABLE
      |-> PRDATA == {21'h00_0000, cur_w_shd_ff};
  endproperty
  a_cw_rd: assert property (p_cw_rd) else $error("width read-back wrong");

  property p_ch_rd;
    setup && !PWRITE && sel_ch ##1 PSEL && PENABLE
      |-> PRDATA == {21'h00_0000, cur_h_shd_ff};
  endproperty
  a_ch_rd: assert property (p_ch_rd) else $error("height read-back wrong");

  property p_stat_rd;
    setup && !PWRITE && sel_st ##1 PSEL && PENABLE
      |-> PRDATA[10:0] == $past(CUR_WIDTH) && PRDATA[26:16] == $past(CUR_HEIGHT);
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status not latched size");

  // writes to a reserved slot and all reads leave every stored value alone
  property p_rsv_wr;
    PSEL && PENABLE && PWRITE && sel_rsv
      |=> $stable(pal_ff) && $stable(cur_w_shd_ff) && $stable(cur_h_shd_ff);
  endproperty
  a_rsv_wr: assert property (p_rsv_wr) else $error("reserved write stored");

  property p_rd_quiet;
    PSEL && PENABLE && !PWRITE
      |=> $stable(pal_ff) && $stable(cur_w_shd_ff) && $stable(cur_h_shd_ff);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read changed a register");

  // palette tables: even entry low, odd entry high, windows kept apart
  property p_pal_even;
    wr_en && sel_w0 |=> pal_ff[0][{$past(pair), 1'b0}] == $past(PWDATA[7:0]);
  endproperty
  a_pal_even: assert property (p_pal_even) else $error("even entry misplaced");

  property p_pal_w1;
    wr_en && sel_w1 |=> pal_ff[1][{$past(pair), 1'b0}] == $past(PWDATA[7:0])
      && pal_ff[1][{$past(pair), 1'b1}] == $past(PWDATA[15:8]);
  endproperty
  a_pal_w1: assert property (p_pal_w1) else $error("window 1 entry misplaced");

  property p_w0_indep;
    wr_en && sel_w0 |=> $stable(pal_ff[1]);
  endproperty
  a_w0_indep: assert property (p_w0_indep) else $error("window 0 write hit window 1");

  // only both sizes at zero give the square; a lone zero width passes through
  property p_lone_zero;
    VSYNC_EVENT && cur_w_shd_ff == 11'h000 && cur_h_shd_ff != 11'h000
      |=> CUR_WIDTH == 11'h000;
  endproperty
  a_lone_zero: assert property (p_lone_zero) else $error("lone zero width altered");

  c_zero_size: cover property (VSYNC_EVENT && both_zero);
  c_bpp2_win1: cover property (PIX_REQ.valid && PIX_REQ.win && PIX_REQ.mode == OSDCP_BPP2);
  c_rsv_read: cover property (setup && !PWRITE && sel_rsv);
  c_write_then_vsync: cover property (wr_en && sel_cw ##[1:20] VSYNC_EVENT);
  c_bpp1_win0: cover property (PIX_REQ.valid && !PIX_REQ.win && PIX_REQ.mode == OSDCP_BPP1);

endmodule

`default_nettype wire
